/* File: src/dlc_pkg.sv */
// Shared constants, types and helpers for the serial link data link control block
package dlc_pkg;

  // Unnumbered control field values
  localparam logic [7:0] CTL_SNRM = 8'h93;
  localparam logic [7:0] CTL_DISC = 8'h53;
  localparam logic [7:0] CTL_UA = 8'h73;
  localparam logic [7:0] CTL_FRMR = 8'h97;

  // Supervisory control values with poll/final set and receive count zero
  localparam logic [4:0] CTL_RR_LOW = 5'h11;
  localparam logic [4:0] CTL_RNR_LOW = 5'h15;

  // Control field layout
  localparam int SEQ_W = 3;
  localparam int NR_LSB = 5;
  localparam int NS_LSB = 1;
  localparam int PF_BIT = 4;
  localparam int IFRM_BIT = 0;

  // Default sizes
  localparam int RXF_DEPTH_DEF = 16;
  localparam int TXB_DEPTH_DEF = 32;

  // Reset values
  localparam logic [SEQ_W-1:0] SEQ_RST = 3'h0;

  typedef logic [SEQ_W-1:0] seq_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PULL = 4'b0010,
    ST_RSP = 4'b0100,
    ST_SEND = 4'b1000
  } state_t;

  typedef enum logic [1:0] {
    MD_NDM = 2'b01,
    MD_NRM = 2'b10
  } mode_t;

  // Frame header handed over by the deframer once the closing flag is seen
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] ctrl;
    logic crc_ok;
    logic [7:0] info_len;
  } rx_hdr_t;

  // Reply header handed to the framer
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] info_len;
  } tx_rsp_t;

  // Sequence count step, modulo eight
  function automatic seq_t seq_inc(input seq_t s);
    seq_inc = seq_t'(s + 3'h1);
  endfunction

  // Sequence count back step, modulo eight
  function automatic seq_t seq_dec(input seq_t s);
    seq_dec = seq_t'(s - 3'h1);
  endfunction

  // Information control field
  function automatic logic [7:0] mk_info(input seq_t ns, input seq_t nr);
    mk_info = {nr, 1'b1, ns, 1'b0};
  endfunction

  // Supervisory control field
  function automatic logic [7:0] mk_sup(input logic [4:0] low, input seq_t nr);
    mk_sup = {nr, low};
  endfunction

endpackage

/* File: src/byte_fifo.sv */
// Synchronous FIFO with valid/ready on both sides and an occupancy count
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready_o = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
  assign out_valid_o = wr_q != rd_q;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign count_o = wr_q - rd_q;
  assign out_data_o = mem_q[rd_q[AW-1:0]];

  // Storage
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  // Pointers
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

/* File: src/msg_ram.sv */
// Single message transmit buffer with registered read data
`timescale 1ns/1ps
module msg_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic core_clk_i,
  input wire logic we_i,
  input wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  // Write port and registered read port
  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule

/* File: src/dlc_slave.sv */
// Slave end of the data link control: link state, sequence counts and replies
//
// Overview of operation
// - Disconnect: answered with acknowledge when disconnected, frame reject when in normal response.
// - Set-normal-response when disconnected enters normal response, replies acknowledge.
// - Other frames when disconnected: frame reject; unsupported in normal response: disconnect, reject.
// - Act only on frames with our address and a good CRC.
// - Two states; I gets RR, RNR or I; RR gets RR or I; RNR gets RR or RNR.
// - Synchronisation ends in normal response with both sequence counts zero.
// - Slave may start resync with frame reject; master then resynchronises fully.
// - In-sequence information frame that fits in the receive FIFO increments receive count, returned in the reply.
// - Acknowledged information frame increments send count and frees the transmit buffer.
// - Polled with pending message: check receive count, send information frame with counts.
// - Acknowledges and polls inside information frames are honoured like supervisory ones.
// - Frames failing CRC are dropped without any reply.
// - Invalid control field: enter disconnected, reply frame reject.
// - Irrecoverable sequence count: enter disconnected, reply frame reject.
// - Unnumbered codes: set-normal 93h, disconnect 53h, acknowledge 73h, reject 97h.
// - Send count one behind: acknowledge but discard as duplicate.
// - Reply receive count equal to unchanged send count: retransmit information frame.
// - Sequence counts are three bits wide, one outstanding message at most.
`timescale 1ns/1ps
module dlc_slave #(
  parameter int RXF_DEPTH = dlc_pkg::RXF_DEPTH_DEF,
  parameter int TXB_DEPTH = dlc_pkg::TXB_DEPTH_DEF
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] node_addr_i,
  input wire logic rx_hdr_valid_i,
  input wire dlc_pkg::rx_hdr_t rx_hdr_i,
  output logic rx_hdr_ready_o,
  input wire logic rx_data_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic rx_data_ready_o,
  output logic tx_rsp_valid_o,
  output dlc_pkg::tx_rsp_t tx_rsp_o,
  input wire logic tx_rsp_ready_i,
  output logic tx_data_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_data_ready_i,
  input wire logic usr_tx_valid_i,
  input wire logic [7:0] usr_tx_data_i,
  input wire logic usr_tx_last_i,
  output logic usr_tx_ready_o,
  output logic usr_rx_valid_o,
  output logic [7:0] usr_rx_data_o,
  input wire logic usr_rx_ready_i,
  output logic linked_o,
  output logic [2:0] nr_o,
  output logic [2:0] ns_o
);
  localparam int TAW = $clog2(TXB_DEPTH);
  localparam int FCW = $clog2(RXF_DEPTH) + 1;

  dlc_pkg::state_t state_q;
  dlc_pkg::mode_t mode_q;
  dlc_pkg::mode_t mode_d;
  dlc_pkg::seq_t nr_q;
  dlc_pkg::seq_t nr_d;
  dlc_pkg::seq_t ns_q;
  dlc_pkg::seq_t ns_d;
  dlc_pkg::seq_t nr_in;
  dlc_pkg::seq_t ns_in;
  logic ackw_q;
  logic ackw_d;
  logic pend_q;
  logic release_d;
  logic keep_d;
  logic keep_q;
  logic rsp_due_q;
  logic rsp_info_d;
  logic rsp_info_q;
  logic [7:0] rsp_ctrl_d;
  logic [7:0] rsp_ctrl_q;
  logic [7:0] rem_q;
  logic [TAW-1:0] wr_ptr_q;
  logic [TAW:0] txlen_q;
  logic [TAW-1:0] rd_ptr_q;
  logic fetch_q;
  logic tx_dv_q;
  logic hit;
  logic take_hdr;
  logic is_info;
  logic is_rr;
  logic is_rnr;
  logic seq_err;
  logic no_space;
  logic space_ok;
  logic fifo_in_ready;
  logic fifo_push;
  logic [FCW-1:0] fifo_cnt;
  logic [8:0] fifo_free;
  logic rx_hs;
  logic usr_wr;
  logic wr_end;

  // Frame acceptance and field extraction
  assign take_hdr = (state_q == dlc_pkg::ST_IDLE) && rx_hdr_valid_i;
  assign hit = take_hdr && (rx_hdr_i.addr == node_addr_i) && rx_hdr_i.crc_ok;
  assign nr_in = rx_hdr_i.ctrl[dlc_pkg::NR_LSB +: dlc_pkg::SEQ_W];
  assign ns_in = rx_hdr_i.ctrl[dlc_pkg::NS_LSB +: dlc_pkg::SEQ_W];
  assign is_info = !rx_hdr_i.ctrl[dlc_pkg::IFRM_BIT] && rx_hdr_i.ctrl[dlc_pkg::PF_BIT];
  assign is_rr = rx_hdr_i.ctrl[4:0] == dlc_pkg::CTL_RR_LOW;
  assign is_rnr = rx_hdr_i.ctrl[4:0] == dlc_pkg::CTL_RNR_LOW;
  assign fifo_free = 9'(RXF_DEPTH) - 9'(fifo_cnt);
  assign space_ok = fifo_free >= {1'b0, rx_hdr_i.info_len};

  // Reply decision for one valid frame
  always_comb begin
    mode_d = mode_q;
    nr_d = nr_q;
    ns_d = ns_q;
    ackw_d = ackw_q;
    release_d = 1'b0;
    keep_d = 1'b0;
    seq_err = 1'b0;
    no_space = 1'b0;
    rsp_info_d = 1'b0;
    rsp_ctrl_d = dlc_pkg::CTL_FRMR;
    if (mode_q == dlc_pkg::MD_NDM) begin
      if (rx_hdr_i.ctrl == dlc_pkg::CTL_DISC) begin
        rsp_ctrl_d = dlc_pkg::CTL_UA;
      end else if (rx_hdr_i.ctrl == dlc_pkg::CTL_SNRM) begin
        mode_d = dlc_pkg::MD_NRM;
        nr_d = dlc_pkg::SEQ_RST;
        ns_d = dlc_pkg::SEQ_RST;
        ackw_d = 1'b0;
        rsp_ctrl_d = dlc_pkg::CTL_UA;
      end else begin
        rsp_ctrl_d = dlc_pkg::CTL_FRMR;
      end
    end else if (!(is_info || is_rr || is_rnr)) begin
      mode_d = dlc_pkg::MD_NDM;
      rsp_ctrl_d = dlc_pkg::CTL_FRMR;
    end else begin
      // Incoming receive count against our send count
      if (ackw_q && (nr_in == dlc_pkg::seq_inc(ns_q))) begin
        ns_d = dlc_pkg::seq_inc(ns_q);
        release_d = 1'b1;
        ackw_d = 1'b0;
      end else if (nr_in == ns_q) begin
        ackw_d = 1'b0;
      end else begin
        seq_err = 1'b1;
      end
      // Incoming send count against our receive count
      if (is_info) begin
        if (ns_in == nr_q) begin
          if (space_ok) begin
            nr_d = dlc_pkg::seq_inc(nr_q);
            keep_d = 1'b1;
          end else begin
            no_space = 1'b1;
          end
        end else if (ns_in != dlc_pkg::seq_dec(nr_q)) begin
          seq_err = 1'b1;
        end
      end
      if (seq_err) begin
        mode_d = dlc_pkg::MD_NDM;
        ns_d = ns_q;
        nr_d = nr_q;
        ackw_d = ackw_q;
        release_d = 1'b0;
        keep_d = 1'b0;
        rsp_ctrl_d = dlc_pkg::CTL_FRMR;
      end else if (no_space || (is_rnr && !fifo_in_ready)) begin
        rsp_ctrl_d = dlc_pkg::mk_sup(dlc_pkg::CTL_RNR_LOW, nr_d);
      end else if (!is_rnr && pend_q && !release_d) begin
        rsp_ctrl_d = dlc_pkg::mk_info(ns_d, nr_d);
        rsp_info_d = 1'b1;
        ackw_d = 1'b1;
      end else begin
        rsp_ctrl_d = dlc_pkg::mk_sup(dlc_pkg::CTL_RR_LOW, nr_d);
      end
    end
  end

  // Link mode and sequence counts
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_q <= dlc_pkg::MD_NDM;
      nr_q <= dlc_pkg::SEQ_RST;
      ns_q <= dlc_pkg::SEQ_RST;
      ackw_q <= 1'b0;
    end else if (hit) begin
      mode_q <= mode_d;
      nr_q <= nr_d;
      ns_q <= ns_d;
      ackw_q <= ackw_d;
    end
  end

  // Reply header held for the framer
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsp_ctrl_q <= dlc_pkg::CTL_FRMR;
      rsp_info_q <= 1'b0;
      rsp_due_q <= 1'b0;
    end else if (take_hdr) begin
      rsp_due_q <= hit;
      if (hit) begin
        rsp_ctrl_q <= rsp_ctrl_d;
        rsp_info_q <= rsp_info_d;
      end
    end
  end

  // Sequencer
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= dlc_pkg::ST_IDLE;
    end else begin
      case (state_q)
        dlc_pkg::ST_IDLE: begin
          if (take_hdr) begin
            if (rx_hdr_i.info_len != 8'h00) begin
              state_q <= dlc_pkg::ST_PULL;
            end else if (hit) begin
              state_q <= dlc_pkg::ST_RSP;
            end
          end
        end
        dlc_pkg::ST_PULL: begin
          if (rx_hs && rem_q == 8'h01) begin
            state_q <= rsp_due_q ? dlc_pkg::ST_RSP : dlc_pkg::ST_IDLE;
          end
        end
        dlc_pkg::ST_RSP: begin
          if (tx_rsp_ready_i) begin
            state_q <= rsp_info_q ? dlc_pkg::ST_SEND : dlc_pkg::ST_IDLE;
          end
        end
        dlc_pkg::ST_SEND: begin
          if (tx_dv_q && tx_data_ready_i && ({1'b0, rd_ptr_q} + 1'b1 == txlen_q)) begin
            state_q <= dlc_pkg::ST_IDLE;
          end
        end
        default: state_q <= dlc_pkg::ST_IDLE;
      endcase
    end
  end

  // Information field intake: kept bytes go to the FIFO, others are drained
  assign rx_data_ready_o = (state_q == dlc_pkg::ST_PULL) && (!keep_q || fifo_in_ready);
  assign rx_hs = rx_data_ready_o && rx_data_valid_i;
  assign fifo_push = rx_hs && keep_q;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rem_q <= 8'h00;
      keep_q <= 1'b0;
    end else if (take_hdr) begin
      rem_q <= rx_hdr_i.info_len;
      keep_q <= hit && keep_d;
    end else if (rx_hs) begin
      rem_q <= rem_q - 8'h01;
    end
  end

  byte_fifo #(
    .WIDTH(8),
    .DEPTH(RXF_DEPTH)
  ) u_rx_fifo (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(fifo_push),
    .in_data_i(rx_data_i),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(usr_rx_valid_o),
    .out_data_o(usr_rx_data_o),
    .out_ready_i(usr_rx_ready_i),
    .count_o(fifo_cnt)
  );

  // Message loading by the user, held until the master acknowledges it
  assign usr_tx_ready_o = !pend_q;
  assign usr_wr = usr_tx_valid_i && usr_tx_ready_o;
  assign wr_end = usr_tx_last_i || (wr_ptr_q == TAW'(TXB_DEPTH - 1));

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_q <= 1'b0;
      wr_ptr_q <= '0;
      txlen_q <= '0;
    end else if (hit && release_d) begin
      pend_q <= 1'b0;
      wr_ptr_q <= '0;
    end else if (usr_wr) begin
      if (wr_end) begin
        pend_q <= 1'b1;
        txlen_q <= {1'b0, wr_ptr_q} + 1'b1;
      end else begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
    end
  end

  msg_ram #(
    .WIDTH(8),
    .DEPTH(TXB_DEPTH)
  ) u_tx_buf (
    .core_clk_i(core_clk_i),
    .we_i(usr_wr),
    .waddr_i(wr_ptr_q),
    .wdata_i(usr_tx_data_i),
    .raddr_i(rd_ptr_q),
    .rdata_o(tx_data_o)
  );

  // Information field readout, one byte per fetch
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_ptr_q <= '0;
      fetch_q <= 1'b0;
      tx_dv_q <= 1'b0;
    end else if (state_q == dlc_pkg::ST_RSP) begin
      rd_ptr_q <= '0;
      fetch_q <= 1'b1;
      tx_dv_q <= 1'b0;
    end else if (state_q == dlc_pkg::ST_SEND) begin
      if (fetch_q) begin
        fetch_q <= 1'b0;
        tx_dv_q <= 1'b1;
      end else if (tx_dv_q && tx_data_ready_i) begin
        tx_dv_q <= 1'b0;
        rd_ptr_q <= rd_ptr_q + 1'b1;
        fetch_q <= ({1'b0, rd_ptr_q} + 1'b1 != txlen_q);
      end
    end
  end

  // Outputs
  assign rx_hdr_ready_o = state_q == dlc_pkg::ST_IDLE;
  assign tx_rsp_valid_o = state_q == dlc_pkg::ST_RSP;
  assign tx_rsp_o.ctrl = rsp_ctrl_q;
  assign tx_rsp_o.info_len = rsp_info_q ? 8'(txlen_q) : 8'h00;
  assign tx_data_valid_o = tx_dv_q && (state_q == dlc_pkg::ST_SEND);
  assign linked_o = mode_q == dlc_pkg::MD_NRM;
  assign nr_o = nr_q;
  assign ns_o = ns_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  a_crc_drop_silent: assert property (
    take_hdr && !rx_hdr_i.crc_ok |=> !rsp_due_q && !tx_rsp_valid_o
  ) else $error("bad CRC frame produced a reply");

  a_ndm_disc_ua: assert property (
    hit && mode_q == dlc_pkg::MD_NDM && rx_hdr_i.ctrl == dlc_pkg::CTL_DISC
    |=> mode_q == dlc_pkg::MD_NDM && rsp_ctrl_q == dlc_pkg::CTL_UA
  ) else $error("disconnect while disconnected not acknowledged");

  a_snrm_sync: assert property (
    hit && mode_q == dlc_pkg::MD_NDM && rx_hdr_i.ctrl == dlc_pkg::CTL_SNRM
    |=> linked_o && nr_q == 3'h0 && ns_q == 3'h0 && rsp_ctrl_q == 8'h73
  ) else $error("set normal response did not synchronise");

  a_ndm_other_rej: assert property (
    hit && mode_q == dlc_pkg::MD_NDM && rx_hdr_i.ctrl != 8'h53 && rx_hdr_i.ctrl != 8'h93
    |=> !linked_o && rsp_ctrl_q == 8'h97
  ) else $error("disconnected slave did not reject frame");

  a_nrm_unnum_rej: assert property (
    hit && linked_o && rx_hdr_i.ctrl[1:0] == 2'b11
    |=> !linked_o && rsp_ctrl_q == dlc_pkg::CTL_FRMR
  ) else $error("unnumbered frame in normal response not rejected");

  a_info_accept: assert property (
    hit && linked_o && is_info && ns_in == nr_q && nr_in == ns_q && space_ok
    |=> nr_q == dlc_pkg::seq_inc($past(nr_q)) && rsp_ctrl_q[7:5] == nr_q
  ) else $error("in-sequence information frame not counted");

  a_ack_release: assert property (
    hit && linked_o && ackw_q && nr_in == dlc_pkg::seq_inc(ns_q) && (is_rr || is_info) && !seq_err
    |=> ns_q == dlc_pkg::seq_inc($past(ns_q)) && !pend_q
  ) else $error("acknowledge did not release transmit buffer");

  a_rnr_no_info: assert property (
    hit && linked_o && is_rnr |=> !rsp_info_q ##1 !tx_data_valid_o
  ) else $error("information sent in answer to receiver not ready");

  a_seq_err_rej: assert property (
    hit && linked_o && is_rr && nr_in != ns_q && nr_in != dlc_pkg::seq_inc(ns_q)
    |=> !linked_o && rsp_ctrl_q == dlc_pkg::CTL_FRMR
  ) else $error("sequence error did not disconnect");

  a_reply_after_hdr: assert property (
    hit && rx_hdr_i.info_len == 8'h00 |=> tx_rsp_valid_o
  ) else $error("valid frame without payload not answered next cycle");
endmodule

/* File: tb/link_master.sv */
// Bus master model facing the slave's frame header, info and reply side
`timescale 1ns/1ps
module link_master #(
  parameter logic [7:0] ADDR = 8'h2a,
  parameter int TO_CYC = 200
) (
  input wire logic core_clk_i,
  output logic rx_hdr_valid_o,
  output dlc_pkg::rx_hdr_t rx_hdr_o,
  input wire logic rx_hdr_ready_i,
  output logic rx_data_valid_o,
  output logic [7:0] rx_data_o,
  input wire logic rx_data_ready_i,
  input wire logic tx_rsp_valid_i,
  input wire dlc_pkg::tx_rsp_t tx_rsp_i,
  output logic tx_rsp_ready_o,
  input wire logic tx_data_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_data_ready_o
);
  int stall = 0;
  int rsp_len = 0;
  logic [7:0] rsp_bytes [$];

  // Idle levels at time zero
  initial begin
    rx_hdr_valid_o = 1'b0;
    rx_hdr_o = '0;
    rx_data_valid_o = 1'b0;
    rx_data_o = 8'h00;
    tx_rsp_ready_o = 1'b0;
    tx_data_ready_o = 1'b0;
  end

  // One frame out, then wait for a reply inside the response window
  task automatic xfer(input logic [7:0] addr, input logic [7:0] ctrl, input logic crc,
                      input logic [7:0] dat [$], output logic got, output logic [7:0] rctl);
    int n;
    int k;
    got = 1'b0;
    rctl = 8'h00;
    n = 0;
    k = 0;
    rsp_bytes = {};
    rx_hdr_valid_o <= 1'b1;
    rx_hdr_o <= {addr, ctrl, crc, 8'(dat.size())};
    do @(posedge core_clk_i); while (!rx_hdr_ready_i);
    rx_hdr_valid_o <= 1'b0;
    rx_hdr_o <= ~{addr, ctrl, crc, 8'(dat.size())};
    foreach (dat[i]) begin
      rx_data_valid_o <= 1'b1;
      rx_data_o <= dat[i];
      do @(posedge core_clk_i); while (!rx_data_ready_i);
    end
    rx_data_valid_o <= 1'b0;
    rx_data_o <= ~rx_data_o;
    while (tx_rsp_valid_i !== 1'b1 && n < TO_CYC) begin
      @(posedge core_clk_i);
      n++;
    end
    if (tx_rsp_valid_i !== 1'b1) return;
    repeat (stall) @(posedge core_clk_i);
    tx_rsp_ready_o <= 1'b1;
    @(posedge core_clk_i);
    rctl = tx_rsp_i.ctrl;
    n = int'(tx_rsp_i.info_len);
    got = 1'b1;
    rsp_len = n;
    tx_rsp_ready_o <= 1'b0;
    // Data ready only raised when the reply carries an information field
    if (n > 0) begin
      tx_data_ready_o <= 1'b1;
      while (rsp_bytes.size() < n && k < TO_CYC) begin
        @(posedge core_clk_i);
        k++;
        if (tx_data_valid_i === 1'b1) rsp_bytes.push_back(tx_data_i);
      end
      tx_data_ready_o <= 1'b0;
    end
  endtask

  // A silent slave earns one retry, a second miss is reported
  task automatic cmd(input logic [7:0] addr, input logic [7:0] ctrl, input logic crc,
                     input logic [7:0] dat [$], output logic err, output logic [7:0] rctl);
    logic got;
    xfer(addr, ctrl, crc, dat, got, rctl);
    if (!got) xfer(addr, ctrl, crc, dat, got, rctl);
    err = !got;
  endtask

  // Disconnect until acknowledged, at most four commands, then set normal response
  task automatic sync(output logic ok);
    logic e;
    logic [7:0] r;
    logic [7:0] none [$];
    r = 8'h00;
    for (int i = 0; i < 4 && r !== dlc_pkg::CTL_UA; i++) cmd(ADDR, dlc_pkg::CTL_DISC, 1'b1, none, e, r);
    cmd(ADDR, dlc_pkg::CTL_SNRM, 1'b1, none, e, r);
    ok = (r === dlc_pkg::CTL_UA);
  endtask
endmodule

/* File: tb/test_serial_link_data_link_control.sv */
// Self-checking bench for the slave data link control
`timescale 1ns/1ps
module test_serial_link_data_link_control;
  localparam logic [7:0] NODE = 8'h2a;
  localparam logic [7:0] UA = dlc_pkg::CTL_UA;
  localparam logic [7:0] FRMR = dlc_pkg::CTL_FRMR;
  localparam logic [4:0] RRL = dlc_pkg::CTL_RR_LOW;
  localparam logic [4:0] RNL = dlc_pkg::CTL_RNR_LOW;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic usr_tx_valid = 1'b0;
  logic [7:0] usr_tx_data = 8'h00;
  logic usr_tx_last = 1'b0;
  logic usr_rx_ready = 1'b0;
  logic hdr_valid, hdr_ready, dat_valid, dat_ready, rsp_valid, rsp_ready, txd_valid, txd_ready;
  dlc_pkg::rx_hdr_t hdr;
  dlc_pkg::tx_rsp_t rsp;
  logic [7:0] dat, txd, usr_rx_data;
  logic usr_tx_ready, usr_rx_valid, linked;
  logic [2:0] nr, ns;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  dlc_slave u_dlc_slave (
    .core_clk_i(core_clk), .nrst_i(nrst), .node_addr_i(NODE),
    .rx_hdr_valid_i(hdr_valid), .rx_hdr_i(hdr), .rx_hdr_ready_o(hdr_ready),
    .rx_data_valid_i(dat_valid), .rx_data_i(dat), .rx_data_ready_o(dat_ready),
    .tx_rsp_valid_o(rsp_valid), .tx_rsp_o(rsp), .tx_rsp_ready_i(rsp_ready),
    .tx_data_valid_o(txd_valid), .tx_data_o(txd), .tx_data_ready_i(txd_ready),
    .usr_tx_valid_i(usr_tx_valid), .usr_tx_data_i(usr_tx_data), .usr_tx_last_i(usr_tx_last),
    .usr_tx_ready_o(usr_tx_ready), .usr_rx_valid_o(usr_rx_valid), .usr_rx_data_o(usr_rx_data),
    .usr_rx_ready_i(usr_rx_ready), .linked_o(linked), .nr_o(nr), .ns_o(ns)
  );

  link_master #(.ADDR(NODE)) u_link_master (
    .core_clk_i(core_clk), .rx_hdr_valid_o(hdr_valid), .rx_hdr_o(hdr), .rx_hdr_ready_i(hdr_ready),
    .rx_data_valid_o(dat_valid), .rx_data_o(dat), .rx_data_ready_i(dat_ready),
    .tx_rsp_valid_i(rsp_valid), .tx_rsp_i(rsp), .tx_rsp_ready_o(rsp_ready),
    .tx_data_valid_i(txd_valid), .tx_data_i(txd), .tx_data_ready_o(txd_ready)
  );

  // 200 MHz clock
  always #2.5 core_clk = ~core_clk;

  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      $display("[FAIL] watchdog expected finish seen hang");
      conclude();
    end
  end

  function automatic logic [7:0] sv(input logic [4:0] lo, input logic [2:0] n);
    return {n, lo};
  endfunction

  function automatic logic [7:0] inf(input logic [2:0] s, input logic [2:0] r);
    return {r, 1'b1, s, 1'b0};
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic st(input logic lnk, input logic [2:0] r, input logic [2:0] s);
    chk("linked", {7'h0, lnk}, {7'h0, linked});
    chk("receive count", {5'h0, r}, {5'h0, nr});
    chk("send count", {5'h0, s}, {5'h0, ns});
  endtask

  task automatic down();
    chk("linked", 8'h00, {7'h0, linked});
  endtask

  // Frame with len counting bytes from seed; reply control compared
  task automatic fr(input logic [7:0] ctl, input int len, input logic [7:0] seed, input logic [7:0] exp);
    logic [7:0] d [$];
    logic e;
    logic [7:0] r;
    for (int i = 0; i < len; i++) d.push_back(seed + 8'(i));
    u_link_master.cmd(NODE, ctl, 1'b1, d, e, r);
    chk("reply control", exp, r);
  endtask

  task automatic drain(input int n, input logic [7:0] seed);
    int k;
    int t;
    k = 0;
    t = 0;
    usr_rx_ready <= 1'b1;
    while (k < n && t < 100) begin
      @(posedge core_clk);
      t++;
      if (usr_rx_valid === 1'b1) begin
        chk("received byte", seed + 8'(k), usr_rx_data);
        k++;
      end
    end
    usr_rx_ready <= 1'b0;
    @(posedge core_clk);
    chk("received count", 8'(n), 8'(k));
    chk("fifo empty", 8'h00, {7'h0, usr_rx_valid});
  endtask

  task automatic load_msg(input int n);
    for (int i = 0; i < n; i++) begin
      usr_tx_valid <= 1'b1;
      usr_tx_data <= 8'hc0 + 8'(i);
      usr_tx_last <= (i == n - 1);
      @(posedge core_clk);
    end
    usr_tx_valid <= 1'b0;
    usr_tx_data <= 8'h3c;
    usr_tx_last <= 1'b0;
    @(posedge core_clk);
    chk("user tx ready", 8'h00, {7'h0, usr_tx_ready});
  endtask

  task automatic chk_msg(input int n);
    chk("reply length field", 8'(n), 8'(u_link_master.rsp_len));
    chk("reply length", 8'(n), 8'(u_link_master.rsp_bytes.size()));
    for (int i = 0; i < u_link_master.rsp_bytes.size(); i++) begin
      chk("reply byte", 8'hc0 + 8'(i), u_link_master.rsp_bytes[i]);
    end
  endtask

  task automatic resync();
    logic ok;
    u_link_master.sync(ok);
    chk("synchronised", 8'h01, {7'h0, ok});
    st(1'b1, 3'h0, 3'h0);
  endtask

  task automatic t_ndm();
    chk("header ready", 8'h01, {7'h0, hdr_ready});
    chk("user tx ready", 8'h01, {7'h0, usr_tx_ready});
    st(1'b0, 3'h0, 3'h0);
    fr(sv(RRL, 3'h0), 0, 8'h00, FRMR);
    down();
    fr(dlc_pkg::CTL_DISC, 0, 8'h00, UA);
    fr(dlc_pkg::CTL_SNRM, 0, 8'h00, UA);
    st(1'b1, 3'h0, 3'h0);
    fr(dlc_pkg::CTL_DISC, 0, 8'h00, FRMR);
    down();
    resync();
    fr(dlc_pkg::CTL_SNRM, 0, 8'h00, FRMR);
    fr(inf(3'h0, 3'h0), 1, 8'hee, FRMR);
    down();
    resync();
    $display("test link modes done");
  endtask

  task automatic t_filter();
    logic e;
    logic [7:0] r;
    logic [7:0] d [$];
    d = {8'h55};
    u_link_master.cmd(NODE + 8'h01, inf(3'h0, 3'h0), 1'b1, d, e, r);
    chk("silent on address", 8'h01, {7'h0, e});
    u_link_master.cmd(NODE, dlc_pkg::CTL_DISC, 1'b0, d, e, r);
    chk("silent on crc", 8'h01, {7'h0, e});
    st(1'b1, 3'h0, 3'h0);
    chk("fifo empty", 8'h00, {7'h0, usr_rx_valid});
    $display("test frame filter done");
  endtask

  task automatic t_seq();
    for (int k = 0; k < 9; k++) begin
      fr(inf(3'(k), 3'h0), 1, 8'(k), sv(RRL, 3'(k + 1)));
      drain(1, 8'(k));
    end
    st(1'b1, 3'h1, 3'h0);
    fr(inf(3'h0, 3'h0), 1, 8'h77, sv(RRL, 3'h1));
    @(posedge core_clk);
    chk("fifo empty", 8'h00, {7'h0, usr_rx_valid});
    st(1'b1, 3'h1, 3'h0);
    fr(inf(3'h3, 3'h0), 1, 8'h77, FRMR);
    down();
    resync();
    $display("test sequence counts done");
  endtask

  task automatic t_fifo();
    u_link_master.stall = 2;
    fr(inf(3'h0, 3'h0), 16, 8'h10, sv(RRL, 3'h1));
    fr(inf(3'h1, 3'h0), 1, 8'h90, sv(RNL, 3'h1));
    fr(sv(RNL, 3'h0), 0, 8'h00, sv(RNL, 3'h1));
    st(1'b1, 3'h1, 3'h0);
    drain(16, 8'h10);
    fr(inf(3'h1, 3'h0), 1, 8'h90, sv(RRL, 3'h2));
    drain(1, 8'h90);
    u_link_master.stall = 0;
    $display("test receive buffer done");
  endtask

  task automatic t_msg();
    load_msg(3);
    fr(sv(RNL, 3'h0), 0, 8'h00, sv(RRL, 3'h2));
    fr(sv(RRL, 3'h0), 0, 8'h00, inf(3'h0, 3'h2));
    chk_msg(3);
    fr(sv(RRL, 3'h0), 0, 8'h00, inf(3'h0, 3'h2));
    chk_msg(3);
    fr(inf(3'h2, 3'h1), 1, 8'h61, sv(RRL, 3'h3));
    st(1'b1, 3'h3, 3'h1);
    chk("user tx ready", 8'h01, {7'h0, usr_tx_ready});
    drain(1, 8'h61);
    fr(8'h01, 0, 8'h00, FRMR);
    down();
    resync();
    fr(sv(RRL, 3'h4), 0, 8'h00, FRMR);
    down();
    $display("test message transfer done");
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Reset, then the scenarios in order
  initial begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_ndm();
    t_filter();
    t_seq();
    t_fifo();
    t_msg();
    conclude();
  end
endmodule
